// *** hdl/nvmac_params.svh ***
// Purpose: Offsets, field positions, unlock keys, config addresses and timing counts for the nonvolatile access block
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef NVMAC_PARAMS_SVH
`define NVMAC_PARAMS_SVH

`define NVMAC_OFF_DATA_LOW     8'h00
`define NVMAC_OFF_DATA_HIGH    8'h04
`define NVMAC_OFF_ADDR_LOW     8'h08
`define NVMAC_OFF_ADDR_HIGH    8'h0C
`define NVMAC_OFF_CONTROL      8'h10
`define NVMAC_OFF_UNLOCK       8'h14
`define NVMAC_OFF_STATUS       8'h18

`define NVMAC_BIT_SPACE_PROG   7
`define NVMAC_BIT_CFG_SPACE    6
`define NVMAC_BIT_LATCH_ONLY   5
`define NVMAC_BIT_ERASE_SEL    4
`define NVMAC_BIT_FAULT        3
`define NVMAC_BIT_ALLOW        2
`define NVMAC_BIT_WRITE_GO     1
`define NVMAC_BIT_READ_GO      0

`define NVMAC_UNLOCK_FIRST     8'h55
`define NVMAC_UNLOCK_SECOND    8'hAA

`define NVMAC_CFG_UID_LAST     15'h0003
`define NVMAC_CFG_DEVID        15'h0006
`define NVMAC_CFG_WORD1        15'h0007
`define NVMAC_CFG_WORD2        15'h0008
`define NVMAC_CFG_BASE         15'h0000

`define NVMAC_WRITE_TIME_NS    2000
`define NVMAC_CLK_PERIOD_NS    5
`define NVMAC_WRITE_CYCLES     ((`NVMAC_WRITE_TIME_NS + `NVMAC_CLK_PERIOD_NS - 1) / `NVMAC_CLK_PERIOD_NS)

`endif

// *** hdl/nvmac_pkg.sv ***
// Purpose: Types for the nonvolatile access block
// Assumes: Constants live in nvmac_params.svh
// Notes:   Memory-side request travels as one struct
package nvmac_pkg;

    typedef enum logic [1:0] {
        NVMAC_SPACE_EEPROM,
        NVMAC_SPACE_FLASH,
        NVMAC_SPACE_CONFIG
    } nvmac_space_e;

    typedef enum logic [1:0] {
        NVMAC_OP_LATCH,
        NVMAC_OP_PROGRAM,
        NVMAC_OP_ERASE,
        NVMAC_OP_ERASE_WRITE
    } nvmac_op_e;

    typedef struct packed {
        logic         valid;
        nvmac_space_e space;
        nvmac_op_e    op;
        logic [14:0]  addr;
        logic [13:0]  data;
    } nvmac_req_s;

endpackage

// *** hdl/nvmac_top.sv ***
// Purpose: Wishbone register front end for flash/EEPROM/config access
// Assumes: Memory arrays answer reads combinationally, accept writes on mem_req_o
// Notes:   All outputs registered; clk_en_i low freezes all state
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "nvmac_params.svh"

module nvmac_top (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              clk_en_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Memory array side
    output nvmac_pkg::nvmac_req_s  mem_req_o,
    output logic      [14:0]       mem_rd_addr_o,
    output nvmac_pkg::nvmac_space_e mem_rd_space_o,
    input  wire logic [13:0]       mem_rd_data_i,
    input  wire logic              mem_abort_i,
    // Processor side
    output logic                   cpu_stall_o,
    output logic                   nvm_done_irq_o
);

    // Register bits
    logic [7:0]  nvm_data_low;
    logic [5:0]  nvm_data_high;
    logic [7:0]  nvm_address_low;
    logic [6:0]  nvm_address_high;
    logic        space_program_select;
    logic        config_space_select;
    logic        latch_load_only;
    logic        erase_select;
    logic        write_fault_flag;
    logic        program_erase_allow;
    logic        write_go;
    logic        read_go;
    logic        nvm_done_flag;
    logic        nvm_done_irq_enable;

    // Sequencer bookkeeping
    logic [1:0]  unlock_stage;
    logic [15:0] busy_count;
    logic        cur_erase;

    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DONE} nvmac_state_e;
    nvmac_state_e state;

    localparam logic [15:0] WRITE_CYCLES = 16'(`NVMAC_WRITE_CYCLES);

    // Bus decode
    logic        wr_req;
    logic        rd_req;
    logic [14:0] addr_word;
    logic [13:0] data_word;
    logic        start_ok;
    logic        wr_go_set;
    logic        rd_go_set;
    nvmac_pkg::nvmac_space_e cur_space;
    nvmac_pkg::nvmac_op_e    next_op;

    // Config access map
    function automatic logic cfg_readable(input logic [14:0] a);
        cfg_readable = (a <= `NVMAC_CFG_UID_LAST) || (a == `NVMAC_CFG_DEVID) ||
                       (a == `NVMAC_CFG_WORD1) || (a == `NVMAC_CFG_WORD2);
    endfunction

    function automatic logic cfg_writable(input logic [14:0] a);
        cfg_writable = (a <= `NVMAC_CFG_UID_LAST);
    endfunction

    // Offset match
    function automatic logic hit(input logic [7:0] off);
        hit = (wb_adr_i == off);
    endfunction

    assign wr_req    = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && clk_en_i;
    assign rd_req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
    assign addr_word = {nvm_address_high, nvm_address_low};
    assign data_word = {nvm_data_high, nvm_data_low};
    assign cur_space = config_space_select  ? nvmac_pkg::NVMAC_SPACE_CONFIG :
                       space_program_select ? nvmac_pkg::NVMAC_SPACE_FLASH :
                                              nvmac_pkg::NVMAC_SPACE_EEPROM;
    assign wr_go_set = wr_req && hit(`NVMAC_OFF_CONTROL) && wb_dat_i[`NVMAC_BIT_WRITE_GO] && !write_go;
    assign rd_go_set = wr_req && hit(`NVMAC_OFF_CONTROL) && wb_dat_i[`NVMAC_BIT_READ_GO] && !write_go;
    // Unlock pair, allow bit and legal config target all needed
    assign start_ok  = (unlock_stage == 2'd2) && program_erase_allow &&
                       (!config_space_select || cfg_writable(addr_word));

    // Mode bits are stored before go
    always_comb begin
        if (cur_space == nvmac_pkg::NVMAC_SPACE_EEPROM) begin
            next_op = nvmac_pkg::NVMAC_OP_ERASE_WRITE;
        end else if (erase_select) begin
            next_op = nvmac_pkg::NVMAC_OP_ERASE;
        end else if (latch_load_only) begin
            next_op = nvmac_pkg::NVMAC_OP_LATCH;
        end else begin
            next_op = nvmac_pkg::NVMAC_OP_PROGRAM;
        end
    end

    // Wishbone ack, one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (clk_en_i) begin
            // Drops the cycle after
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Read data mux
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (clk_en_i && rd_req) begin
            case (wb_adr_i)
                `NVMAC_OFF_DATA_LOW:  wb_dat_o <= {24'h00_0000, nvm_data_low};
                `NVMAC_OFF_DATA_HIGH: wb_dat_o <= {26'h000_0000, nvm_data_high};
                `NVMAC_OFF_ADDR_LOW:  wb_dat_o <= {24'h00_0000, nvm_address_low};
                `NVMAC_OFF_ADDR_HIGH: wb_dat_o <= {25'h000_0000, nvm_address_high};
                `NVMAC_OFF_CONTROL:   wb_dat_o <= {24'h00_0000, space_program_select, config_space_select,
                                                   latch_load_only, erase_select, write_fault_flag,
                                                   program_erase_allow, write_go, read_go};
                `NVMAC_OFF_STATUS:    wb_dat_o <= {30'h0000_0000, nvm_done_irq_enable, nvm_done_flag};
                default:              wb_dat_o <= 32'h0000_0000;  // Unlock port and unmapped read 0
            endcase
        end
    end

    // Address registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nvm_address_low  <= 8'h00;
            nvm_address_high <= 7'h00;
        end else if (wr_req && !write_go) begin
            // Frozen while busy
            if (hit(`NVMAC_OFF_ADDR_LOW)) begin
                nvm_address_low <= wb_dat_i[7:0];
            end
            if (hit(`NVMAC_OFF_ADDR_HIGH)) begin
                nvm_address_high <= wb_dat_i[6:0];
            end
        end
    end

    // Data registers: software write or read fetch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nvm_data_low  <= 8'h00;
            nvm_data_high <= 6'h00;
        end else if (clk_en_i) begin
            // Fetch beats a write
            if (read_go) begin
                if (config_space_select && !cfg_readable(addr_word)) begin
                    nvm_data_low  <= 8'h00;
                    nvm_data_high <= 6'h00;
                end else begin
                    nvm_data_low  <= mem_rd_data_i[7:0];
                    // EEPROM keeps high byte
                    nvm_data_high <= cur_space == nvmac_pkg::NVMAC_SPACE_EEPROM ?
                                     nvm_data_high : mem_rd_data_i[13:8];
                end
            end else if (wr_req && !write_go) begin
                if (hit(`NVMAC_OFF_DATA_LOW)) begin
                    nvm_data_low <= wb_dat_i[7:0];
                end
                if (hit(`NVMAC_OFF_DATA_HIGH)) begin
                    nvm_data_high <= wb_dat_i[5:0];
                end
            end
        end
    end

    // Unlock sequencer; port itself stores nothing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unlock_stage <= 2'd0;
        end else if (wr_req) begin
            if (hit(`NVMAC_OFF_UNLOCK)) begin
                // First byte restarts
                if (wb_dat_i[7:0] == `NVMAC_UNLOCK_FIRST) begin
                    unlock_stage <= 2'd1;
                end else if (wb_dat_i[7:0] == `NVMAC_UNLOCK_SECOND && unlock_stage == 2'd1) begin
                    unlock_stage <= 2'd2;
                end else begin
                    unlock_stage <= 2'd0;
                end
            end else begin
                unlock_stage <= 2'd0;   // Any other write breaks the sequence
            end
        end
    end

    // Control bits written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            space_program_select <= 1'b0;
            config_space_select  <= 1'b0;
            latch_load_only      <= 1'b0;
            program_erase_allow  <= 1'b0;
            nvm_done_irq_enable  <= 1'b0;
        end else if (wr_req && !write_go) begin
            if (hit(`NVMAC_OFF_CONTROL)) begin
                space_program_select <= wb_dat_i[`NVMAC_BIT_SPACE_PROG];
                config_space_select  <= wb_dat_i[`NVMAC_BIT_CFG_SPACE];
                latch_load_only      <= wb_dat_i[`NVMAC_BIT_LATCH_ONLY];
                program_erase_allow  <= wb_dat_i[`NVMAC_BIT_ALLOW];
            end
            if (hit(`NVMAC_OFF_STATUS)) begin
                nvm_done_irq_enable <= wb_dat_i[1];
            end
        end
    end

    // Erase select, cleared by hardware after erase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            erase_select <= 1'b0;
        end else if (clk_en_i) begin
            // Hardware clear wins
            if (state == ST_DONE && cur_erase) begin
                erase_select <= 1'b0;
            end else if (wr_req && !write_go && hit(`NVMAC_OFF_CONTROL)) begin
                erase_select <= wb_dat_i[`NVMAC_BIT_ERASE_SEL];
            end
        end
    end

    // Go bits: set-only by software, cleared by hardware
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            read_go <= 1'b0;
        end else if (clk_en_i) begin
            // High for one cycle only
            read_go <= rd_go_set && !wb_dat_i[`NVMAC_BIT_WRITE_GO];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_go <= 1'b0;
        end else if (clk_en_i) begin
            // Only completion clears it
            if (state == ST_DONE) begin
                write_go <= 1'b0;
            end else if (wr_go_set && start_ok) begin
                write_go <= 1'b1;
            end
        end
    end

    // Fault flag: set wins over software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_fault_flag <= 1'b0;
        end else if (clk_en_i) begin
            if ((wr_go_set && !start_ok) || (state == ST_BUSY && mem_abort_i)) begin
                write_fault_flag <= 1'b1;
            end else if (wr_req && hit(`NVMAC_OFF_CONTROL) && !wb_dat_i[`NVMAC_BIT_FAULT]) begin
                // Write 0 to clear
                write_fault_flag <= 1'b0;
            end
        end
    end

    // Timed operation sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state      <= ST_IDLE;
            busy_count <= 16'h0000;
            cur_erase  <= 1'b0;
            mem_req_o  <= '0;
        end else if (clk_en_i) begin
            // One-cycle pulse
            mem_req_o.valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (wr_go_set && start_ok) begin
                        mem_req_o.valid <= 1'b1;
                        mem_req_o.space <= cur_space;
                        mem_req_o.op    <= next_op;
                        mem_req_o.addr  <= addr_word;
                        mem_req_o.data  <= data_word;
                        cur_erase       <= next_op == nvmac_pkg::NVMAC_OP_ERASE;
                        busy_count      <= next_op == nvmac_pkg::NVMAC_OP_LATCH ? 16'h0001 : WRITE_CYCLES;
                        state           <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    // Abort ends it early
                    if (mem_abort_i || busy_count <= 16'h0001) begin
                        state <= ST_DONE;
                    end else begin
                        busy_count <= busy_count - 16'h0001;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Done flag: set wins over software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nvm_done_flag <= 1'b0;
        end else if (clk_en_i) begin
            // Not for latch loads
            if (state == ST_DONE && mem_req_o.op != nvmac_pkg::NVMAC_OP_LATCH) begin
                nvm_done_flag <= 1'b1;
            end else if (wr_req && hit(`NVMAC_OFF_STATUS) && wb_dat_i[0]) begin
                nvm_done_flag <= 1'b0;
            end
        end
    end

    // Processor-facing outputs and memory read address/space
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_stall_o    <= 1'b0;
            nvm_done_irq_o <= 1'b0;
            mem_rd_addr_o  <= 15'h0000;
            mem_rd_space_o <= nvmac_pkg::NVMAC_SPACE_EEPROM;
        end else if (clk_en_i) begin
            cpu_stall_o    <= (wr_go_set && start_ok && cur_space != nvmac_pkg::NVMAC_SPACE_EEPROM) ||
                              (state == ST_BUSY && mem_req_o.space != nvmac_pkg::NVMAC_SPACE_EEPROM &&
                               !(mem_abort_i || busy_count <= 16'h0001));
            nvm_done_irq_o <= nvm_done_flag && nvm_done_irq_enable;
            // Lags registers a cycle
            mem_rd_addr_o  <= addr_word;
            mem_rd_space_o <= cur_space;
        end
    end

endmodule

// *** tb/nvmac_checker.sv ***
// Purpose: Port-level assertions for nvmac_top
// Assumes: clk_en_i held high by the bench
// Notes:   Bound to every nvmac_top instance
`timescale 1ns/1ps
`include "nvmac_params.svh"
module nvmac_checker (
    // Clock and reset
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    clk_en_i,
    // Wishbone
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [7:0]              wb_adr_i,
    input wire logic [3:0]              wb_sel_i,
    input wire logic [31:0]             wb_dat_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o,
    // Memory side
    input wire nvmac_pkg::nvmac_req_s   mem_req_o,
    input wire logic [14:0]             mem_rd_addr_o,
    input wire nvmac_pkg::nvmac_space_e mem_rd_space_o,
    input wire logic [13:0]             mem_rd_data_i,
    input wire logic                    mem_abort_i,
    // Processor side
    input wire logic                    cpu_stall_o,
    input wire logic                    nvm_done_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en_i;
    wire rd = take && !wb_we_i;
    wire go_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == `NVMAC_OFF_CONTROL && wb_dat_i[1];
    wire v = mem_req_o.valid;
    wire ee = mem_req_o.space == nvmac_pkg::NVMAC_SPACE_EEPROM;
    wire lat = mem_req_o.op == nvmac_pkg::NVMAC_OP_LATCH;

    AST_REQ_CAUSE: assert property (v |-> $past(go_wr))
        else $error("memory request without a go write");
    AST_REQ_PULSE: assert property (v |=> !v)
        else $error("memory request longer than one cycle");
    AST_EE_OP: assert property (v && ee |-> mem_req_o.op == nvmac_pkg::NVMAC_OP_ERASE_WRITE)
        else $error("EEPROM request not erase-then-write");
    AST_CFG_RANGE: assert property (v && mem_req_o.space == nvmac_pkg::NVMAC_SPACE_CONFIG
        |-> mem_req_o.addr <= `NVMAC_CFG_UID_LAST)
        else $error("write to read-only config word");
    AST_STALL_HOLD: assert property (v && !ee && !lat |-> cpu_stall_o [*8])
        else $error("processor not stalled during flash operation");
    AST_EE_NO_STALL: assert property (v && ee |-> !cpu_stall_o)
        else $error("stall during EEPROM write");
    AST_UNLOCK_RD: assert property (rd && wb_adr_i == `NVMAC_OFF_UNLOCK |=> wb_dat_o == 32'h0)
        else $error("unlock port reads nonzero");
    AST_DH_RD: assert property (rd && wb_adr_i == `NVMAC_OFF_DATA_HIGH |=> wb_dat_o[7:6] == 2'b00)
        else $error("data high top bits nonzero");
    AST_AH_RD: assert property (rd && wb_adr_i == `NVMAC_OFF_ADDR_HIGH |=> !wb_dat_o[7])
        else $error("address high top bit nonzero");

    cover property (v && ee);
    cover property (v && lat);
    cover property (v && mem_req_o.space == nvmac_pkg::NVMAC_SPACE_CONFIG);
endmodule

bind nvmac_top nvmac_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o), .mem_rd_addr_o(mem_rd_addr_o),
    .mem_rd_space_o(mem_rd_space_o), .mem_rd_data_i(mem_rd_data_i), .mem_abort_i(mem_abort_i),
    .cpu_stall_o(cpu_stall_o), .nvm_done_irq_o(nvm_done_irq_o));

// *** tb/nvmac_mem_model.sv ***
// Purpose: Behavioural flash, EEPROM and config arrays
// Assumes: Rows of eight words, reads answered combinationally
// Notes:   Abort raised only on the bench's command
`timescale 1ns/1ps
module nvmac_mem_model (
    // Clock
    input  wire logic                    clk_i,
    // Requests and reads
    input  wire nvmac_pkg::nvmac_req_s   req_i,
    input  wire logic [14:0]             rd_addr_i,
    input  wire nvmac_pkg::nvmac_space_e rd_space_i,
    output logic      [13:0]             rd_data_o,
    // Commanded fault
    input  wire logic                    abort_cmd_i,
    output logic                         abort_o
);
    logic [13:0] arr [4][512];
    logic [13:0] lat [8];
    logic [7:0]  ld = 8'h00;
    logic [8:0]  a;
    assign a = req_i.addr[8:0];
    assign abort_o = abort_cmd_i;
    assign rd_data_o = arr[rd_space_i][rd_addr_i[8:0]];
    initial begin
        for (int s = 0; s < 4; s++) begin
            for (int i = 0; i < 512; i++) begin
                arr[s][i] = 14'(i * 3 + s + 7);
            end
        end
    end
    always @(posedge clk_i) begin
        if (req_i.valid === 1'b1) begin
            case (req_i.op)
                nvmac_pkg::NVMAC_OP_LATCH: begin
                    lat[a[2:0]] <= req_i.data;
                    ld[a[2:0]] <= 1'b1;
                end
                nvmac_pkg::NVMAC_OP_PROGRAM: begin
                    for (int i = 0; i < 8; i++) begin
                        if (ld[i]) arr[req_i.space][{a[8:3], 3'(i)}] <= lat[i];
                    end
                    arr[req_i.space][a] <= req_i.data;
                    ld <= 8'h00;
                end
                nvmac_pkg::NVMAC_OP_ERASE: begin
                    for (int i = 0; i < 8; i++) arr[req_i.space][{a[8:3], 3'(i)}] <= 14'h3FFF;
                end
                default: arr[req_i.space][a] <= req_i.data;
            endcase
        end
    end
endmodule

// *** tb/tb.sv ***
// Purpose: Self-checking bench for nvmac_top
// Assumes: Register access over classic Wishbone
// Notes:   Expected array contents kept in em
`timescale 1ns/1ps
`include "nvmac_params.svh"
module tb;
    logic                    clk_i = 0;
    logic                    rst_i = 1;
    logic                    cyc = 0;
    logic                    stb = 0;
    logic                    we = 0;
    logic                    abort_cmd = 0;
    logic [7:0]              adr = 0;
    logic [31:0]             wdat = 0;
    logic [31:0]             q;
    logic [31:0]             r;
    logic [31:0]             wb_dat_o;
    logic                    wb_ack_o;
    logic                    stall;
    logic                    irq;
    logic                    abort;
    nvmac_pkg::nvmac_req_s   req;
    logic [14:0]             rd_addr;
    nvmac_pkg::nvmac_space_e rd_space;
    logic [13:0]             rd_data;
    logic [13:0]             em [4][512];
    logic [13:0]             d;
    logic [14:0]             a;
    int                      num_errors = 0;
    int                      checks = 0;
    int                      seed = 32'h9b1e;
    int                      ticks = 0;
    int                      nreq = 0;
    int                      n0;
    logic [7:0]              rc [5] = '{8'h86, 8'h86, 8'h86, 8'h82, 8'h46};
    logic [15:0]             rk [5] = '{16'h0000, 16'hAA55, 16'h5555, 16'h55AA, 16'h55AA};

    nvmac_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .mem_req_o(req), .mem_rd_addr_o(rd_addr), .mem_rd_space_o(rd_space),
        .mem_rd_data_i(rd_data), .mem_abort_i(abort), .cpu_stall_o(stall), .nvm_done_irq_o(irq));
    nvmac_mem_model u_mem (.clk_i(clk_i), .req_i(req), .rd_addr_i(rd_addr), .rd_space_i(rd_space),
        .rd_data_o(rd_data), .abort_cmd_i(abort_cmd), .abort_o(abort));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        ticks++;
        if (req.valid === 1'b1) nreq++;
        if (ticks == 30000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= ad;
        wdat <= dt;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        q = wb_dat_o;
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic setad(input logic [14:0] ad, input logic [13:0] dd);
        wb(1, `NVMAC_OFF_ADDR_LOW, {24'h0, ad[7:0]});
        wb(1, `NVMAC_OFF_ADDR_HIGH, {25'h0, ad[14:8]});
        wb(1, `NVMAC_OFF_DATA_LOW, {24'h0, dd[7:0]});
        wb(1, `NVMAC_OFF_DATA_HIGH, {26'h0, dd[13:8]});
    endtask
    // Mode write, optional unlock pair, go write, poll until done
    task automatic go(input logic [7:0] c, input logic [15:0] key, input bit ab);
        int n;
        n = 0;
        wb(1, `NVMAC_OFF_CONTROL, {24'h0, c & 8'hFC});
        if (key != 0) begin
            wb(1, `NVMAC_OFF_UNLOCK, {24'h0, key[15:8]});
            wb(1, `NVMAC_OFF_UNLOCK, {24'h0, key[7:0]});
        end
        wb(1, `NVMAC_OFF_CONTROL, {24'h0, c});
        if (ab) begin
            repeat (20) @(posedge clk_i);
            abort_cmd <= 1;
            @(posedge clk_i);
            abort_cmd <= 0;
        end
        do begin
            wb(0, `NVMAC_OFF_CONTROL, 0);
            n++;
        end while (q[1] !== 1'b0 && n < 300);
    endtask
    task automatic rdw(input logic [7:0] c, input logic [14:0] ad);
        logic [7:0] lo;
        wb(1, `NVMAC_OFF_ADDR_LOW, {24'h0, ad[7:0]});
        wb(1, `NVMAC_OFF_ADDR_HIGH, {25'h0, ad[14:8]});
        wb(1, `NVMAC_OFF_CONTROL, {24'h0, c});
        wb(1, `NVMAC_OFF_CONTROL, {24'h0, c | 8'h01});
        wb(0, `NVMAC_OFF_DATA_LOW, 0);
        lo = q[7:0];
        wb(0, `NVMAC_OFF_DATA_HIGH, 0);
        r = {16'h0, q[7:0], lo};
    endtask

    initial begin
        for (int s = 0; s < 4; s++)
            for (int i = 0; i < 512; i++) em[s][i] = 14'(i * 3 + s + 7);
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < 8; i++) begin
            wb(0, 8'(i * 4), 0);
            check(q, 0);
        end
        $display("test reset done");
        d = 14'($random(seed));
        setad(15'h7FFF, 14'h3FFF);
        wb(0, `NVMAC_OFF_ADDR_HIGH, 0);
        check(q, 32'h7F);
        wb(0, `NVMAC_OFF_DATA_HIGH, 0);
        check(q, 32'h3F);
        wb(1, `NVMAC_OFF_ADDR_LOW, {24'h0, d[7:0]});
        wb(0, `NVMAC_OFF_ADDR_LOW, 0);
        check(q, {24'h0, d[7:0]});
        wb(1, `NVMAC_OFF_UNLOCK, 32'h55);
        wb(0, `NVMAC_OFF_UNLOCK, 0);
        check(q, 0);
        wb(1, 8'h1C, 32'hFF);
        wb(0, 8'h1C, 0);
        check(q, 0);
        $display("test widths done");
        a = 15'($random(seed)) & 15'h01FF;
        d = 14'($random(seed));
        setad(a, d);
        go(8'h36, 16'h55AA, 0);
        check(q & 32'h0A, 0);
        em[0][a[8:0]] = d;
        rdw(8'h00, a);
        check(r & 32'hFF, {24'h0, d[7:0]});
        wb(0, `NVMAC_OFF_CONTROL, 0);
        check(q & 32'h01, 0);
        wb(1, `NVMAC_OFF_STATUS, 32'h2);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq}, 1);
        wb(1, `NVMAC_OFF_STATUS, 32'h3);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq}, 0);
        $display("test eeprom done");
        for (int i = 0; i < 5; i++) begin
            n0 = nreq;
            setad(i == 4 ? 15'h0007 : 15'h0010, 14'h1234);
            go(rc[i], rk[i], 0);
            check(q & 32'h0A, 32'h08);
            check(nreq, n0);
        end
        $display("test refusal done");
        a = 15'($random(seed)) & 15'h01F8;
        for (int i = 0; i < 8; i++) begin
            d = 14'($random(seed));
            setad(a | 15'(i), d);
            go(i < 7 ? 8'hA6 : 8'h86, 16'h55AA, 0);
            if (i < 7) begin
                rdw(8'h80, a | 15'(i));
                check(r, {18'h0, em[1][a[8:0] | 9'(i)]});
            end
            em[1][a[8:0] | 9'(i)] = d;
        end
        for (int i = 0; i < 8; i++) begin
            rdw(8'h80, a | 15'(i));
            check(r, {18'h0, em[1][a[8:0] | 9'(i)]});
        end
        rdw(8'h00, a);
        check(r & 32'hFF, {24'h0, em[0][a[8:0]][7:0]});
        go(8'h96, 16'h55AA, 0);
        check(q & 32'h1A, 0);
        rdw(8'h80, a | 15'h3);
        check(r, 32'h3FFF);
        $display("test flash done");
        d = 14'($random(seed));
        setad(15'h0002, d);
        go(8'h46, 16'h55AA, 0);
        rdw(8'h40, 15'h0002);
        check(r, {18'h0, d});
        rdw(8'h40, 15'h0006);
        check(r, {18'h0, em[2][6]});
        rdw(8'h40, 15'h0009);
        check(r, 0);
        $display("test config done");
        setad(15'h0100, 14'h0AAA);
        go(8'h86, 16'h55AA, 1);
        check(q & 32'h0A, 32'h08);
        $display("test abort done");
        tally_and_finish();
    end
endmodule
